// ===== hw/socket_status_change_events.sv
// Status-change event latching and interrupt gating for one card socket.
// Assumes the host drives a one-cycle read or write strobe on clk, and
// the card status and card detect pins arrive from outside this clock.
`timescale 1ns/1ps

// Operation
// - Flags record change only, not state
// - Writing one clears flag, zero keeps
// - Force register write sets matching flag
// - Host-bus reset clears every flag
// - Card reset release may re-set flags
// - Flag set at enable raises interrupt
// - Upper bits 31 to 4 read zero
// - Power-cycle state change sets bit 3
// - Second card detect change sets bit 2
// - First card detect change sets bit 1
// - Card status change sets bit 0
// - CardBus card: rising edge only
// - 16-bit card: both edges set bit 0
// - Enables never stop flags from setting
// - Enable bit 3 gates power event
// - Detect enable field: 11 on, else off
// - Enable bit 0 gates card status event
// - Force writes also show in present state
module socket_status_change_events (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // Register access port
    input  wire logic                                reg_read,
    input  wire logic                                reg_write,
    input  wire logic [socket_change_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [socket_change_pkg::DATA_W-1:0] reg_wdata,
    output logic      [socket_change_pkg::DATA_W-1:0] reg_rdata,
    output logic                                     reg_rvalid,
    // Socket status sources
    input  wire logic                                power_cycle_state,
    input  wire logic                                card_detect_pin_one_n,
    input  wire logic                                card_detect_pin_two_n,
    input  wire logic                                card_status_pin,
    input  wire logic                                card_is_cardbus,
    input  wire logic                                card_reset,
    // Interrupt to host
    output logic                                     status_change_irq
);
    import socket_change_pkg::*;

    // Pin synchronisers, order {detect2, detect1, status}
    logic [2:0]        pin_meta_reg;    // First stage, read by stage two only
    logic [2:0]        pin_sync_reg;    // Second stage, safe to use

    // Change detection state
    logic [FLAG_W-1:0] mon_prev_reg;    // Monitored bits one clock back
    logic              card_reset_prev_reg;  // For release edge

    // Software-visible state
    logic [FLAG_W-1:0] flags_reg;       // Sticky event flags
    logic [FLAG_W-1:0] enables_reg;     // Interrupt enables
    logic [FLAG_W-1:0] forced_reg;      // Force overlay on present state

    // Output flops
    logic [DATA_W-1:0] rdata_reg;
    logic              rvalid_reg;
    logic              irq_reg;

    // Decode and combinational nets
    logic [FLAG_W-1:0] mon;             // Present monitored levels
    logic [FLAG_W-1:0] changed;         // Any-direction change
    logic              status_rise;     // Card status rising edge
    logic [FLAG_W-1:0] hw_set;          // Hardware-detected events
    logic              reset_release;   // Card reset just released
    logic [FLAG_W-1:0] reassert_set;    // Re-set after card reset
    logic              wr_flags;
    logic              wr_enables;
    logic              wr_force;
    logic [FLAG_W-1:0] force_set;       // Software-forced events
    logic [FLAG_W-1:0] clr_vec;         // Write-one-to-clear mask
    logic [FLAG_W-1:0] set_vec;         // All set sources merged
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] eff_en;          // Enables after field decode
    logic              irq_next;
    logic [FLAG_W-1:0] present_view;    // Present-state low bits
    logic [DATA_W-1:0] read_word;       // Selected read value

    // Two-flop synchroniser for the card pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {card_detect_pin_two_n, card_detect_pin_one_n,
                             card_status_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Power state is on-chip logic on clk, so no synchroniser
    assign mon = {power_cycle_state, pin_sync_reg};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon_prev_reg        <= 4'h0;
            card_reset_prev_reg <= 1'h0;
        end else begin
            mon_prev_reg        <= mon;
            card_reset_prev_reg <= card_reset;
        end
    end

    assign changed     = mon ^ mon_prev_reg;
    assign status_rise = mon[BIT_CARD_STATUS] & ~mon_prev_reg[BIT_CARD_STATUS];

    assign hw_set[BIT_POWER]   = changed[BIT_POWER];
    assign hw_set[BIT_DETECT2] = changed[BIT_DETECT2];
    assign hw_set[BIT_DETECT1] = changed[BIT_DETECT1];
    assign hw_set[BIT_CARD_STATUS] = card_is_cardbus ? status_rise
                                                     : changed[BIT_CARD_STATUS];

    // re-set after card reset
    // Detect pins are active low, so a low pin means card present
    assign reset_release = card_reset_prev_reg & ~card_reset;
    assign reassert_set  = {1'b0, ~pin_sync_reg[2], ~pin_sync_reg[1],
                            pin_sync_reg[0]} & {FLAG_W{reset_release}};

    // Register write decode
    assign wr_flags   = reg_write && (reg_addr == OFF_FLAGS);
    assign wr_enables = reg_write && (reg_addr == OFF_ENABLES);
    assign wr_force   = reg_write && (reg_addr == OFF_FORCE);

    assign force_set = wr_force ? reg_wdata[FLAG_W-1:0] : FLAGS_RESET;
    assign clr_vec   = wr_flags ? reg_wdata[FLAG_W-1:0] : FLAGS_RESET;

    assign set_vec = hw_set | reassert_set | force_set;

    // Per-bit sticky flags; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi = gi + 1) begin : g_flag
            assign flags_next[gi] = set_vec[gi] | (flags_reg[gi] & ~clr_vec[gi]);

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    flags_reg[gi] <= FLAGS_RESET[gi];
                end else begin
                    flags_reg[gi] <= flags_next[gi];
                end
            end
        end
    endgenerate

    // Enable register, plain read/write of the low bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enables_reg <= ENABLES_RESET;
        end else if (wr_enables) begin
            enables_reg <= reg_wdata[FLAG_W-1:0];
        end
    end

    assign eff_en[BIT_POWER]   = enables_reg[BIT_POWER];
    // both detect bits or none
    // Reserved codes 01 and 10 are treated as off: the safe reading
    assign eff_en[BIT_DETECT2] = (enables_reg[BIT_DETECT2:BIT_DETECT1]
                                  == DETECT_ENABLE_ON);
    assign eff_en[BIT_DETECT1] = eff_en[BIT_DETECT2];
    assign eff_en[BIT_CARD_STATUS] = enables_reg[BIT_CARD_STATUS];

    assign irq_next = |(flags_reg & eff_en);

    // Interrupt output flop; one clock behind flags and enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // forced bits shown as present
    // An overlay bit holds until its own input really moves again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            forced_reg <= FLAGS_RESET;
        end else begin
            forced_reg <= force_set | (forced_reg & ~changed);
        end
    end

    // Present-state view, live levels merged with the force overlay
    assign present_view = mon | forced_reg;

    // upper bits read zero
    // Force register is write-only and reads zero, as do unmapped offsets
    assign read_word =
        (reg_addr == OFF_FLAGS)   ? {{UPPER_W{1'b0}}, flags_reg}    :
        (reg_addr == OFF_ENABLES) ? {{UPPER_W{1'b0}}, enables_reg}  :
        (reg_addr == OFF_PRESENT) ? {{UPPER_W{1'b0}}, present_view} :
                                    RDATA_RESET;

    // Read data flop; a read in a write cycle sees the old value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg  <= RDATA_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= reg_read ? read_word : RDATA_RESET;
            rvalid_reg <= reg_read;
        end
    end

    // Outputs straight from flops
    assign reg_rdata         = rdata_reg;
    assign reg_rvalid        = rvalid_reg;
    assign status_change_irq = irq_reg;

    // Read answers never carry reserved bits
    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        reg_rvalid |-> (reg_rdata[DATA_W-1:FLAG_W] == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved read bits not zero");

    // Written ones clear unless an event lands together
    property p_w1c_clear;
        @(posedge clk) disable iff (rst)
        (wr_flags && (set_vec == '0))
            |=> (flags_reg == ($past(flags_reg) & ~$past(reg_wdata[FLAG_W-1:0])));
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("flag clear by one wrong");

    // Force write bits end up set
    property p_force_sets;
        @(posedge clk) disable iff (rst)
        wr_force |=> ((flags_reg & $past(reg_wdata[FLAG_W-1:0]))
                      == $past(reg_wdata[FLAG_W-1:0]));
    endproperty
    a_force_sets: assert property (p_force_sets)
        else $error("forced flag not set");

    // Power-cycle change sets bit 3 whatever the enable
    property p_power_change;
        @(posedge clk) disable iff (rst)
        (power_cycle_state != $past(power_cycle_state)) |=> flags_reg[BIT_POWER];
    endproperty
    a_power_change: assert property (p_power_change)
        else $error("power change not flagged");

    // Synced detect change is flagged on the next clock
    property p_detect_change;
        @(posedge clk) disable iff (rst)
        (pin_sync_reg[1] != $past(pin_sync_reg[1])) |=> flags_reg[BIT_DETECT1];
    endproperty
    a_detect_change: assert property (p_detect_change)
        else $error("detect1 change not flagged");

    // CardBus falling edge alone leaves bit 0 clear
    property p_cardbus_fall;
        @(posedge clk) disable iff (rst)
        (card_is_cardbus && mon_prev_reg[0] && !mon[0] && !force_set[0]
         && !reassert_set[0] && !flags_reg[0]) |=> !flags_reg[BIT_CARD_STATUS];
    endproperty
    a_cardbus_fall: assert property (p_cardbus_fall)
        else $error("cardbus falling edge flagged");

    // 16-bit card flags either edge
    property p_16bit_edges;
        @(posedge clk) disable iff (rst)
        (!card_is_cardbus && changed[BIT_CARD_STATUS])
            |=> flags_reg[BIT_CARD_STATUS];
    endproperty
    a_16bit_edges: assert property (p_16bit_edges)
        else $error("16-bit status edge missed");

    // Enabled power flag shows on the interrupt next clock
    property p_irq_follow;
        @(posedge clk) disable iff (rst)
        (flags_reg[BIT_POWER] && enables_reg[BIT_POWER]) |=> status_change_irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("enabled flag gave no interrupt");

    // Enable write over an old flag raises interrupt two clocks on
    property p_enable_old_flag;
        @(posedge clk) disable iff (rst)
        (wr_enables && reg_wdata[0] && flags_reg[0] && !clr_vec[0])
            |-> ##2 status_change_irq;
    endproperty
    a_enable_old_flag: assert property (p_enable_old_flag)
        else $error("old flag ignored at enable");

    // Half-set detect field never interrupts
    property p_detect_reserved;
        @(posedge clk) disable iff (rst)
        ((enables_reg[2] != enables_reg[1])
         && ((flags_reg & {enables_reg[3], 2'b00, enables_reg[0]}) == '0))
            |=> !status_change_irq;
    endproperty
    a_detect_reserved: assert property (p_detect_reserved)
        else $error("reserved detect code interrupted");

    // Card reset release with status high sets bit 0
    property p_reset_reassert;
        @(posedge clk) disable iff (rst)
        (reset_release && pin_sync_reg[0]) |=> flags_reg[BIT_CARD_STATUS];
    endproperty
    a_reset_reassert: assert property (p_reset_reassert)
        else $error("status not re-set after card reset");

endmodule : socket_status_change_events

// ===== common/socket_change_pkg.sv
// Constants for the socket status-change event block.
// Assumes a 32-bit register port with byte offsets on an 8-bit address.
package socket_change_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ENABLES = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PRESENT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FORCE   = 8'h0C;

    // Field positions shared by flags, enables and present state
    localparam int BIT_CARD_STATUS = 0;
    localparam int BIT_DETECT1     = 1;
    localparam int BIT_DETECT2     = 2;
    localparam int BIT_POWER       = 3;

    // Detect enable field value that lets insertion/removal interrupt
    localparam logic [1:0] DETECT_ENABLE_ON = 2'h3;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAGS_RESET   = 4'h0;
    localparam logic [FLAG_W-1:0] ENABLES_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET   = 32'h00000000;

    // Width of the always-zero upper part of each register
    localparam int UPPER_W = DATA_W - FLAG_W;

endpackage : socket_change_pkg

// ===== testbench/socket_card_model.sv
// Card-side model: detect pins and status line of one seated card.
// Assumes a single bench clock; pins move just after a rising edge.
`timescale 1ns/1ps
module socket_card_model (
    // Clock
    input  wire logic clk,
    // Pins toward the socket
    output logic      detect_one_n,
    output logic      detect_two_n,
    output logic      status_line
);
    // Seated and quiet at power-up, so reset release shows no change
    initial begin
        detect_one_n = 1'b0;
        detect_two_n = 1'b0;
        status_line  = 1'b0;
    end
    // Both detect pins follow the card; pulled up when it is out
    task automatic seat(input logic present);
        @(posedge clk);
        detect_one_n <= ~present;
        detect_two_n <= ~present;
    endtask : seat
    // Status-change line level
    task automatic drive_status(input logic level);
        @(posedge clk);
        status_line <= level;
    endtask : drive_status
endmodule : socket_card_model

// ===== testbench/testbench.sv
// Self-checking bench for the socket status-change event block.
// Assumes the card model owns the pins and the bench plays host software.
`timescale 1ns/1ps
module testbench;
    import socket_change_pkg::*;

    logic              clk;       // 250 MHz clock
    logic              rst;       // Async reset
    logic              reg_read;  // Read strobe
    logic              reg_write; // Write strobe
    logic [ADDR_W-1:0] reg_addr;  // Byte offset
    logic [DATA_W-1:0] reg_wdata; // Write data
    logic [DATA_W-1:0] reg_rdata; // Read data
    logic              reg_rvalid;
    logic              power_cycle_state;
    logic              card_is_cardbus;
    logic              card_reset;
    logic              det_one_n; // Pins from the card
    logic              det_two_n;
    logic              status_line;
    logic              status_change_irq;
    int                n_fail;    // Mismatches
    int                cmp_count; // Comparisons

    socket_card_model card (.clk(clk), .detect_one_n(det_one_n),
        .detect_two_n(det_two_n), .status_line(status_line));

    socket_status_change_events dut (.clk(clk), .rst(rst), .reg_read(reg_read),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .power_cycle_state(power_cycle_state), .card_detect_pin_one_n(det_one_n),
        .card_detect_pin_two_n(det_two_n), .card_status_pin(status_line),
        .card_is_cardbus(card_is_cardbus), .card_reset(card_reset),
        .status_change_irq(status_change_irq));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compare and count; four-state so an unknown never matches
    task automatic check(input string name, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // Read; the answer stands one cycle only, so look right after it lands
    task automatic rd(input string name, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check({name, " valid"}, {31'h0, reg_rvalid}, 32'h1);
        check(name, reg_rdata, exp);
    endtask : rd

    // Interrupt line once flag and gate have settled
    task automatic irq(input logic exp);
        repeat (3) @(posedge clk);
        #1;
        check("irq", {31'h0, status_change_irq}, {31'h0, exp});
    endtask : irq

    // Pin path needs two sync stages plus the flag edge
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic t_reset();
        rd("flags rst", OFF_FLAGS, 32'h0);
        rd("enables rst", OFF_ENABLES, 32'h0);
        rd("unmapped", 8'h10, 32'h0);
        irq(1'b0);
        wr(OFF_ENABLES, 32'hFFFFFFFF);
        rd("enables upper", OFF_ENABLES, 32'hF);
        wr(OFF_ENABLES, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_power();
        @(posedge clk);
        power_cycle_state <= 1'b1;
        settle();
        rd("pwr rise", OFF_FLAGS, 32'h8);
        irq(1'b0);
        wr(OFF_FLAGS, 32'h0);
        rd("after w0", OFF_FLAGS, 32'h8);
        wr(OFF_FLAGS, 32'h8);
        rd("after w1", OFF_FLAGS, 32'h0);
        @(posedge clk);
        power_cycle_state <= 1'b0;
        settle();
        rd("pwr fall", OFF_FLAGS, 32'h8);
        wr(OFF_ENABLES, 32'h8);
        irq(1'b1);
        wr(OFF_FLAGS, 32'h8);
        irq(1'b0);
        wr(OFF_ENABLES, 32'h0);
        $display("test power done");
    endtask : t_power

    task automatic t_detect();
        wr(OFF_ENABLES, 32'h2);
        card.seat(1'b0);
        settle();
        rd("pulled", OFF_FLAGS, 32'h6);
        rd("present out", OFF_PRESENT, 32'h6);
        irq(1'b0);
        wr(OFF_ENABLES, 32'h4);
        irq(1'b0);
        wr(OFF_ENABLES, 32'h6);
        irq(1'b1);
        wr(OFF_FLAGS, 32'h6);
        irq(1'b0);
        card.seat(1'b1);
        settle();
        rd("seated", OFF_FLAGS, 32'h6);
        rd("present in", OFF_PRESENT, 32'h0);
        wr(OFF_FLAGS, 32'h6);
        wr(OFF_ENABLES, 32'h0);
        $display("test detect done");
    endtask : t_detect

    task automatic t_status();
        card.drive_status(1'b1);
        settle();
        rd("cb rise", OFF_FLAGS, 32'h1);
        irq(1'b0);
        // Enable over a pending flag must still interrupt
        wr(OFF_ENABLES, 32'h1);
        irq(1'b1);
        wr(OFF_FLAGS, 32'h1);
        irq(1'b0);
        card.drive_status(1'b0);
        settle();
        rd("cb fall", OFF_FLAGS, 32'h0);
        @(posedge clk);
        card_is_cardbus <= 1'b0;
        card.drive_status(1'b1);
        settle();
        rd("16b rise", OFF_FLAGS, 32'h1);
        wr(OFF_FLAGS, 32'h1);
        card.drive_status(1'b0);
        settle();
        rd("16b fall", OFF_FLAGS, 32'h1);
        wr(OFF_FLAGS, 32'h1);
        wr(OFF_ENABLES, 32'h0);
        $display("test status done");
    endtask : t_status

    task automatic t_force();
        wr(OFF_FORCE, 32'hF);
        rd("forced", OFF_FLAGS, 32'hF);
        rd("forced present", OFF_PRESENT, 32'hF);
        rd("force reads", OFF_FORCE, 32'h0);
        wr(OFF_FLAGS, 32'hF);
        rd("forced clear", OFF_FLAGS, 32'h0);
        $display("test force done");
    endtask : t_force

    task automatic t_card_reset();
        @(posedge clk);
        card_reset <= 1'b1;
        card.drive_status(1'b1);
        settle();
        wr(OFF_FLAGS, 32'hF);
        rd("held", OFF_FLAGS, 32'h0);
        @(posedge clk);
        card_reset <= 1'b0;
        settle();
        rd("released", OFF_FLAGS, 32'h7);
        $display("test card reset done");
    endtask : t_card_reset

    // Host reset in mid-run with flags and enables set
    task automatic t_host_reset();
        wr(OFF_ENABLES, 32'hF);
        irq(1'b1);
        // Pins quiet before reset so release shows no edge
        card.drive_status(1'b0);
        settle();
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd("flags hrst", OFF_FLAGS, 32'h0);
        rd("enables hrst", OFF_ENABLES, 32'h0);
        irq(1'b0);
        $display("test host reset done");
    endtask : t_host_reset

    // Verdict and end of run
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // Watchdog: tests need about 0.8 us
    initial begin
        #40000;
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst = 1'b1;
        reg_read = 1'b0;
        reg_write = 1'b0;
        power_cycle_state = 1'b0;
        card_is_cardbus = 1'b1;
        card_reset = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_power();
        t_detect();
        t_status();
        t_force();
        t_card_reset();
        t_host_reset();
        end_sim();
    end
endmodule : testbench
